// *** pkg/jep_pkg.sv ***
// constants for the command-mode nonvolatile access block
package jep_pkg;
	// ****************************************
	// command word layout
	// ****************************************
	localparam int WORD_W = 16;
	localparam int DATA_LSB = 0;
	localparam int OP_LSB = 8;
	localparam int OP_W = 8;
	// ****************************************
	// command opcodes
	// ****************************************
	localparam logic [7:0] OP_EE_WR_EN = 8'h4a;
	localparam logic [7:0] OP_EE_ADDR_HI = 8'h4b;
	localparam logic [7:0] OP_EE_ADDR_LO = 8'h4c;
	localparam logic [7:0] OP_EE_DATA_LD = 8'h4d;
	localparam logic [7:0] OP_EE_DATA_LATCH = 8'h4e;
	localparam logic [7:0] OP_EE_COMMIT = 8'h4f;
	localparam logic [7:0] OP_EE_POLL = 8'h40;
	localparam logic [7:0] OP_RD_EN = 8'h5a;
	localparam logic [7:0] OP_RD_ADDR_HI = 8'h5b;
	localparam logic [7:0] OP_RD_ADDR_LO = 8'h5c;
	localparam logic [7:0] OP_RD_DATA = 8'h5d;
	localparam logic [7:0] OP_FUSE_EN = 8'h6a;
	localparam logic [7:0] OP_FUSE_DATA = 8'h6b;
	localparam logic [7:0] OP_FUSE_EXT_WR = 8'h6c;
	localparam logic [7:0] OP_FUSE_EXT_POLL = 8'h6d;
	localparam logic [7:0] OP_FUSE_HIGH_WR = 8'h6f;
	localparam logic [7:0] OP_FUSE_HIGH_POLL = 8'h60;
	localparam logic [7:0] OP_FUSE_LOW_WR = 8'h61;
	localparam logic [7:0] OP_FUSE_LOW_POLL = 8'h62;
	// ****************************************
	// reset and response values
	// ****************************************
	localparam logic [7:0] FUSE_RST = 8'hff;
	localparam logic [7:0] EE_RST = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] STATUS_DONE = 8'h01;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_WAIT_NS = 4000;
	localparam int WRITE_WAIT_CYC = WRITE_WAIT_NS / CLK_PERIOD_NS;
endpackage

// *** rtl/jep_nv_access.sv ***
// command-mode eeprom and fuse access behind the test port
`timescale 1ns/1ps
module jep_nv_access #(
	parameter int ADDR_W = 9,
	parameter int PAGE_BITS = 2,
	parameter int WRITE_CYC = jep_pkg::WRITE_WAIT_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// test port link
	input wire logic i_tck,
	input wire logic i_tdi,
	input wire logic i_shift,
	input wire logic i_update,
	input wire logic i_programming_command_mode,
	output logic o_tdo,
	// status and fuse state
	output logic o_busy,
	output logic [7:0] o_fuse_ext,
	output logic [7:0] o_fuse_high,
	output logic [7:0] o_fuse_low
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PAGE = 1 << PAGE_BITS;
	localparam int CNT_W = $clog2(WRITE_CYC + 1);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic tck_d;
	logic upd_d;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			tck_d <= 1'b0;
			upd_d <= 1'b0;
		end else begin
			sync1 <= {i_programming_command_mode, i_update, i_shift, i_tdi, i_tck};
			sync2 <= sync1;
			tck_d <= sync2[0];
			upd_d <= sync2[3];
		end
	end
	wire tck_rise = sync2[0] & ~tck_d;
	wire upd_rise = sync2[3] & ~upd_d;
	wire cmd_mode = sync2[4];
	wire do_shift = tck_rise & sync2[2];
	wire execute = upd_rise & cmd_mode;

	// ****************************************
	// command decode
	// ****************************************
	logic [jep_pkg::WORD_W-1:0] sr;
	wire [7:0] op = sr[jep_pkg::OP_LSB +: jep_pkg::OP_W];
	wire [7:0] arg = sr[jep_pkg::DATA_LSB +: 8];
	logic busy;
	logic [CNT_W-1:0] cnt;
	logic ee_wr_en;
	logic rd_en;
	logic fuse_en;
	logic [7:0] addr_hi;
	logic [7:0] addr_lo;
	logic [7:0] data_latch;
	logic [7:0] fuse_data;
	logic [7:0] mem [DEPTH];
	logic [7:0] pbuf [PAGE];
	logic [PAGE-1:0] pvalid;

	function automatic logic is_op(input logic [7:0] o, input logic [7:0] c);
		return o == c;
	endfunction

	wire idle_exec = execute & ~busy;
	wire [ADDR_W-1:0] addr = ADDR_W'({addr_hi, addr_lo});
	wire [ADDR_W-1:0] page_base = addr & ~ADDR_W'(PAGE - 1);
	wire [PAGE_BITS-1:0] pidx = addr_lo[PAGE_BITS-1:0];
	wire is_poll = is_op(op, jep_pkg::OP_EE_POLL)
		| is_op(op, jep_pkg::OP_FUSE_EXT_POLL)
		| is_op(op, jep_pkg::OP_FUSE_HIGH_POLL)
		| is_op(op, jep_pkg::OP_FUSE_LOW_POLL);
	wire is_read = is_op(op, jep_pkg::OP_RD_DATA);
	wire do_commit = idle_exec & ee_wr_en & is_op(op, jep_pkg::OP_EE_COMMIT);
	wire fw_ext = idle_exec & fuse_en & is_op(op, jep_pkg::OP_FUSE_EXT_WR);
	wire fw_high = idle_exec & fuse_en & is_op(op, jep_pkg::OP_FUSE_HIGH_WR);
	wire fw_low = idle_exec & fuse_en & is_op(op, jep_pkg::OP_FUSE_LOW_WR);
	wire start_wr = do_commit | fw_ext | fw_high | fw_low;
	wire [7:0] rd_byte = rd_en ? mem[addr] : jep_pkg::BYTE_ZERO;
	wire [7:0] status = busy ? jep_pkg::BYTE_ZERO : jep_pkg::STATUS_DONE;
	wire [7:0] resp = is_poll ? status : (is_read ? rd_byte : jep_pkg::BYTE_ZERO);
	wire [jep_pkg::WORD_W-1:0] next_sr = execute
		? {op, resp}
		: (do_shift ? {sync2[1], sr[jep_pkg::WORD_W-1:1]} : sr);

	// ****************************************
	// shift register and returned data
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sr <= '0;
			o_tdo <= 1'b0;
		end else begin
			sr <= next_sr;
			o_tdo <= next_sr[0];
		end
	end

	// ****************************************
	// mode enables and address, data latches
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ee_wr_en <= 1'b0;
			rd_en <= 1'b0;
			fuse_en <= 1'b0;
			addr_hi <= 8'h00;
			addr_lo <= 8'h00;
			data_latch <= 8'h00;
			fuse_data <= jep_pkg::FUSE_RST;
		end else if (!cmd_mode) begin
			ee_wr_en <= 1'b0;
			rd_en <= 1'b0;
			fuse_en <= 1'b0;
		end else if (idle_exec) begin
			if (is_op(op, jep_pkg::OP_EE_WR_EN)) begin
				ee_wr_en <= 1'b1;
				rd_en <= 1'b0;
				fuse_en <= 1'b0;
			end else if (is_op(op, jep_pkg::OP_RD_EN)) begin
				rd_en <= 1'b1;
				ee_wr_en <= 1'b0;
				fuse_en <= 1'b0;
			end else if (is_op(op, jep_pkg::OP_FUSE_EN)) begin
				fuse_en <= 1'b1;
				ee_wr_en <= 1'b0;
				rd_en <= 1'b0;
			end else if (is_op(op, jep_pkg::OP_EE_ADDR_HI)
				| is_op(op, jep_pkg::OP_RD_ADDR_HI)) begin
				addr_hi <= arg;
			end else if (is_op(op, jep_pkg::OP_EE_ADDR_LO)
				| is_op(op, jep_pkg::OP_RD_ADDR_LO)) begin
				addr_lo <= arg;
			end else if (is_op(op, jep_pkg::OP_EE_DATA_LD)) begin
				data_latch <= arg;
			end else if (is_op(op, jep_pkg::OP_FUSE_DATA)) begin
				fuse_data <= arg;
			end
		end
	end

	// ****************************************
	// page buffer
	// ****************************************
	wire latch_byte = idle_exec & ee_wr_en & is_op(op, jep_pkg::OP_EE_DATA_LATCH);
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pvalid <= '0;
			for (int i = 0; i < PAGE; i++) begin
				pbuf[i] <= 8'h00;
			end
		end else if (do_commit) begin
			pvalid <= '0;
		end else if (latch_byte) begin
			pbuf[pidx] <= data_latch;
			pvalid[pidx] <= 1'b1;
		end
	end

	// ****************************************
	// nonvolatile array and fuses
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= jep_pkg::EE_RST;
			end
			o_fuse_ext <= jep_pkg::FUSE_RST;
			o_fuse_high <= jep_pkg::FUSE_RST;
			o_fuse_low <= jep_pkg::FUSE_RST;
		end else begin
			if (do_commit) begin
				for (int i = 0; i < PAGE; i++) begin
					if (pvalid[i]) begin
						mem[page_base | ADDR_W'(i)] <= pbuf[i];
					end
				end
			end
			if (fw_ext) begin
				o_fuse_ext <= fuse_data;
			end
			if (fw_high) begin
				o_fuse_high <= fuse_data;
			end
			if (fw_low) begin
				o_fuse_low <= fuse_data;
			end
		end
	end

	// ****************************************
	// write completion timer
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			busy <= 1'b0;
			cnt <= '0;
			o_busy <= 1'b0;
		end else begin
			if (start_wr) begin
				busy <= 1'b1;
				cnt <= CNT_W'(WRITE_CYC - 1);
				o_busy <= 1'b1;
			end else if (busy && cnt == '0) begin
				busy <= 1'b0;
				o_busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - CNT_W'(1);
			end
		end
	end
endmodule // jep_nv_access

// *** test/jep_nv_monitor.sv ***
// port assertions for the nonvolatile access block
`timescale 1ns/1ps
module jep_nv_monitor #(
	parameter int WRITE_CYC = 1000
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// link
	input wire logic i_shift,
	input wire logic i_update,
	input wire logic i_programming_command_mode,
	// outputs
	input wire logic o_tdo,
	input wire logic o_busy,
	input wire logic [7:0] o_fuse_ext,
	input wire logic [7:0] o_fuse_high,
	input wire logic [7:0] o_fuse_low
);
	int cnt;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) cnt <= 0;
		else cnt <= o_busy ? cnt + 1 : 0;
	end
	sequence s_start; $rose(o_busy); endsequence
	sequence s_cmd;
		$past(i_update, 3) && $past(i_programming_command_mode, 3);
	endsequence
	AST_BUSY_CAUSE: assert property (s_start |-> s_cmd)
		else $error("busy rose without a command");
	AST_BUSY_HOLD: assert property (s_start |-> o_busy [*8])
		else $error("busy dropped early");
	AST_BUSY_LEN: assert property ($fell(o_busy) |-> cnt == WRITE_CYC)
		else $error("busy length wrong");
	AST_FUSE_EXT: assert property ($changed(o_fuse_ext) |-> o_busy || $past(o_busy))
		else $error("ext fuse changed outside write");
	AST_FUSE_HIGH: assert property ($changed(o_fuse_high) |-> o_busy || $past(o_busy))
		else $error("high fuse changed outside write");
	AST_FUSE_LOW: assert property ($changed(o_fuse_low) |-> o_busy || $past(o_busy))
		else $error("low fuse changed outside write");
	AST_TDO_CAUSE: assert property ($changed(o_tdo) |-> $past(i_shift, 3) or s_cmd)
		else $error("tdo changed without shift or command");
endmodule // jep_nv_monitor
bind jep_nv_access jep_nv_monitor #(.WRITE_CYC(WRITE_CYC)) u_mon (
	.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_shift(i_shift),
	.i_update(i_update),
	.i_programming_command_mode(i_programming_command_mode),
	.o_tdo(o_tdo), .o_busy(o_busy), .o_fuse_ext(o_fuse_ext),
	.o_fuse_high(o_fuse_high), .o_fuse_low(o_fuse_low));

// *** test/jep_prog_model.sv ***
// link programmer model that shifts command words
`timescale 1ns/1ps
module jep_prog_model (
	// clock
	input wire logic i_clk_sys,
	// link
	input wire logic i_tdo,
	output logic o_tck,
	output logic o_tdi,
	output logic o_shift,
	output logic o_update,
	output logic o_mode
);
	initial {o_tck, o_tdi, o_shift, o_update, o_mode} = 5'h01;
	// word lsb first, returns the previous answer
	task automatic send(input logic [15:0] w, output logic [15:0] r);
		// every command word travels here, page buffer load and read included
		o_shift <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			o_tdi <= w[i];
			repeat (10) @(negedge i_clk_sys);
			r[i] = i_tdo;
			o_tck <= 1'b1;
			repeat (10) @(negedge i_clk_sys);
			o_tck <= 1'b0;
		end
		o_shift <= 1'b0;
		o_tdi <= ~w[15];
		o_update <= 1'b1;
		repeat (6) @(negedge i_clk_sys);
		o_update <= 1'b0;
		repeat (6) @(negedge i_clk_sys);
	endtask
endmodule // jep_prog_model

// *** test/jep_nv_access_tb.sv ***
// self-checking bench for the nonvolatile access block
`timescale 1ns/1ps
module jep_nv_access_tb;
	localparam int WC = 400;
	logic i_clk_sys, i_rstn, tck, tdi, shift, upd, mode, tdo, busy;
	logic [7:0] fe, fh, fl, d, a;
	logic [15:0] r, v;
	logic [23:0] f;
	int err_count, check_count, seed, ad;
	int mem [int];
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	jep_prog_model pm (.i_clk_sys(i_clk_sys), .i_tdo(tdo), .o_tck(tck),
		.o_tdi(tdi), .o_shift(shift), .o_update(upd), .o_mode(mode));
	jep_nv_access #(.WRITE_CYC(WC)) dut (.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn), .i_tck(tck), .i_tdi(tdi), .i_shift(shift),
		.i_update(upd), .i_programming_command_mode(mode), .o_tdo(tdo),
		.o_busy(busy), .o_fuse_ext(fe), .o_fuse_high(fh), .o_fuse_low(fl));
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, x);
		pm.send({op, x}, r);
	endtask
	task automatic ask(input logic [7:0] op, x);
		cmd(op, x);
		cmd(8'h00, 8'h00);
		v = r;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		give_verdict();
	end
	initial begin
		seed = 73;
		i_rstn = 1'b0;
		repeat (10) @(negedge i_clk_sys);
		i_rstn = 1'b1;
		chk({busy, fe, fh, fl}, 32'h00ffffff);
		repeat (4) @(negedge i_clk_sys);
		cmd(8'h4a, 8'h00);
		for (int p = 0; p < 2; p++) begin
			cmd(8'h4b, 8'h01);
			for (int i = 0; i < 4; i++) begin
				d = 8'($random(seed));
				a = 8'(16 + 4 * p + i);
				mem[256 + a] = d;
				cmd(8'h4c, a);
				cmd(8'h4d, d);
				cmd(8'h4e, 8'h00);
			end
			cmd(8'h4f, 8'h00);
			chk(busy, 1);
			ask(8'h40, 8'h00);
			chk(v, 16'h4000);
			ask(8'h40, 8'h00);
			chk(v, 16'h4001);
		end
		$display("end test eeprom write");
		cmd(8'h5a, 8'h00);
		for (int i = 0; i < 9; i++) begin
			a = (i < 8) ? 8'(16 + i) : 8'h20;
			ad = ((i < 8) ? 256 : 0) + a;
			cmd(8'h5b, (i < 8) ? 8'h01 : 8'h00);
			cmd(8'h5c, a);
			ask(8'h5d, 8'h00);
			d = mem.exists(ad) ? 8'(mem[ad]) : jep_pkg::EE_RST;
			chk(v, {8'h5d, d});
		end
		$display("end test eeprom read");
		f = 24'hffffff;
		cmd(8'h6a, 8'h00);
		for (int k = 0; k < 3; k++) begin
			d = 8'($random(seed));
			f[23 - 8 * k -: 8] = d;
			cmd(8'h6b, d);
			cmd(k == 0 ? 8'h6c : k == 1 ? 8'h6f : 8'h61, 8'h00);
			repeat (WC) @(negedge i_clk_sys);
			ask(k == 0 ? 8'h6d : k == 1 ? 8'h60 : 8'h62, 8'h00);
			chk(v[7:0], 8'h01);
			chk({fe, fh, fl}, f);
		end
		$display("end test fuses");
		pm.o_mode <= 1'b0;
		cmd(8'h6a, 8'h00);
		cmd(8'h6b, 8'h00);
		cmd(8'h6c, 8'h00);
		chk({busy, fe, fh, fl}, {8'h00, f});
		$display("end test mode off");
		give_verdict();
	end
endmodule // jep_nv_access_tb
